/* File: core/eba_ctrl.sv */
// EEPROM byte access controller: address, data and control registers on the I/O port,
// the byte array, read strobes, interlocked write launch, stalls and ready request.
// Assumes I/O requests are synchronous to the CPU clock and the oscillator is a free pin.
`timescale 1ns/100ps
module eba_ctrl
  import eba_pkg::*;
#(
  parameter logic [EBA_CNT_W-1:0] ATOMIC_OSC_CYC = EBA_CNT_W'(EBA_WRITE_OSC_CYC),
  parameter logic [EBA_CNT_W-1:0] SPLIT_OSC_CYC  = EBA_CNT_W'(EBA_SPLIT_OSC_CYC)
)
(
  input  wire logic        I_CLK_SYS,
  input  wire logic        I_RST_N,
  input  wire eba_io_req_s I_IO_REQ,
  input  wire logic        I_GLOBAL_IRQ_EN,
  input  wire logic        I_FLASH_SELFPROG_ENABLE,
  input  wire logic        I_CAL_OSC,
  output logic [7:0]       O_IO_RDATA,
  output logic             O_CPU_STALL,
  output logic             O_READY_IRQ,
  output logic             O_PROG_BUSY
);

  // ----------------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------------
  logic [7:0]            mem_q [EBA_MEM_BYTES];
  logic [EBA_ADDR_W-1:0] addr_q;
  logic [EBA_ADDR_W-1:0] addr_d;
  logic [7:0]            data_q;
  logic [7:0]            data_d;
  logic [1:0]            mode_q;
  logic [1:0]            mode_d;
  logic                  rie_q;
  logic                  rie_d;
  logic                  arm_q;
  logic                  arm_d;
  logic [2:0]            arm_cnt_q;
  logic [2:0]            arm_cnt_d;
  logic                  launch_q;
  logic                  launch_d;
  logic [2:0]            stall_q;
  logic [2:0]            stall_d;
  logic [7:0]            rdata_q;
  logic [7:0]            rdata_d;
  eba_state_e            state_q;
  eba_state_e            state_d;
  logic [EBA_ADDR_W-1:0] op_addr_q;
  logic [7:0]            op_data_q;
  eba_mode_e             op_mode_q;

  // ----------------------------------------------------------------------------
  // Oscillator synchroniser and edge detect
  // ----------------------------------------------------------------------------
  logic osc_s1_q;
  logic osc_s2_q;
  logic osc_s3_q;
  logic osc_tick;

  always_ff @(posedge I_CLK_SYS)
  begin
    osc_s1_q <= I_CAL_OSC;
    osc_s2_q <= osc_s1_q;
    osc_s3_q <= osc_s2_q;
  end

  assign osc_tick = osc_s2_q && !osc_s3_q;

  // ----------------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------------
  logic busy;
  logic wr_lo;
  logic wr_hi;
  logic wr_data;
  logic wr_ctrl;
  logic set_read;
  logic set_launch;
  logic set_arm;
  logic read_go;
  logic launch_go;
  logic [7:0] ctrl_rd;
  logic [7:0] addr_hi_rd;

  assign busy       = launch_q;
  assign wr_lo      = I_IO_REQ.wr && (I_IO_REQ.idx == EBA_IDX_ADDR_LO);
  assign wr_hi      = I_IO_REQ.wr && (I_IO_REQ.idx == EBA_IDX_ADDR_HI);
  assign wr_data    = I_IO_REQ.wr && (I_IO_REQ.idx == EBA_IDX_DATA);
  assign wr_ctrl    = I_IO_REQ.wr && (I_IO_REQ.idx == EBA_IDX_CTRL);
  assign set_read   = wr_ctrl && I_IO_REQ.wdata[EBA_BIT_READ];
  assign set_launch = wr_ctrl && I_IO_REQ.wdata[EBA_BIT_LAUNCH];
  assign set_arm    = wr_ctrl && I_IO_REQ.wdata[EBA_BIT_ARM] && !I_IO_REQ.wdata[EBA_BIT_LAUNCH];
  assign read_go    = set_read && !busy;
  assign launch_go  = set_launch && arm_q && !busy;

  // Read strobe has no storage, so it reads back zero
  assign ctrl_rd    = {2'b00, mode_q, rie_q, arm_q, launch_q, 1'b0};
  assign addr_hi_rd = {7'h00, addr_q[EBA_ADDR_W-1]};

  // ----------------------------------------------------------------------------
  // Register next values
  // ----------------------------------------------------------------------------
  always_comb
  begin
    addr_d = addr_q;
    if (!busy && wr_lo)
    begin
      addr_d[7:0] = I_IO_REQ.wdata;
    end
    if (!busy && wr_hi)
    begin
      addr_d[EBA_ADDR_W-1] = I_IO_REQ.wdata[0];
    end
  end

  always_comb
  begin
    data_d = data_q;
    if (read_go)
    begin
      data_d = mem_q[addr_q];
    end
    else if (wr_data)
    begin
      data_d = I_IO_REQ.wdata;
    end
  end

  always_comb
  begin
    mode_d = mode_q;
    rie_d  = rie_q;
    if (wr_ctrl)
    begin
      rie_d = I_IO_REQ.wdata[EBA_BIT_RIE];
      if (!busy)
      begin
        mode_d = I_IO_REQ.wdata[EBA_BIT_MODE_HI:EBA_BIT_MODE_LO];
      end
    end
  end

  // Arm lasts four cycles; a second arm write restarts the window
  always_comb
  begin
    arm_d     = arm_q;
    arm_cnt_d = arm_cnt_q;
    if (set_arm)
    begin
      arm_d     = 1'b1;
      arm_cnt_d = EBA_ARM_HOLD_CYC;
    end
    else if (arm_q)
    begin
      arm_cnt_d = arm_cnt_q - 3'h1;
      if (arm_cnt_q == 3'h1)
      begin
        arm_d = 1'b0;
      end
    end
  end

  always_comb
  begin
    stall_d = stall_q;
    if (read_go)
    begin
      stall_d = EBA_RD_STALL_CYC;
    end
    else if (launch_go)
    begin
      stall_d = EBA_WR_STALL_CYC;
    end
    else if (stall_q != 3'h0)
    begin
      stall_d = stall_q - 3'h1;
    end
  end

  always_comb
  begin
    unique case (I_IO_REQ.idx)
      EBA_IDX_ADDR_LO: rdata_d = addr_q[7:0];
      EBA_IDX_ADDR_HI: rdata_d = addr_hi_rd;
      EBA_IDX_DATA:    rdata_d = data_q;
      EBA_IDX_CTRL:    rdata_d = ctrl_rd;
    endcase
    if (!I_IO_REQ.rd)
    begin
      rdata_d = rdata_q;
    end
  end

  // ----------------------------------------------------------------------------
  // Programming sequencer
  // ----------------------------------------------------------------------------
  logic                 timer_start;
  logic                 timer_done;
  logic [EBA_CNT_W-1:0] timer_count;

  assign timer_count = (op_mode_q == EBA_MODE_ATOMIC || op_mode_q == EBA_MODE_RSVD) ?
                       ATOMIC_OSC_CYC : SPLIT_OSC_CYC;

  // Flash self-programming blocks the start, not a count already running
  assign timer_start = (state_q == EBA_ST_FLASH) && !I_FLASH_SELFPROG_ENABLE;

  always_comb
  begin
    state_d  = state_q;
    launch_d = launch_q;
    unique case (state_q)
      EBA_ST_IDLE:
      begin
        if (launch_go)
        begin
          state_d  = EBA_ST_FLASH;
          launch_d = 1'b1;
        end
      end
      EBA_ST_FLASH:
      begin
        if (timer_start)
        begin
          state_d = EBA_ST_RUN;
        end
      end
      EBA_ST_RUN:
      begin
        if (timer_done)
        begin
          state_d  = EBA_ST_IDLE;
          launch_d = 1'b0;
        end
      end
      default:
      begin
        state_d  = EBA_ST_IDLE;
        launch_d = 1'b0;
      end
    endcase
  end

  eba_prog_timer u_timer
  (
    .i_clk   (I_CLK_SYS),
    .i_rst_n (I_RST_N),
    .i_start (timer_start),
    .i_count (timer_count),
    .i_tick  (osc_tick),
    .o_done  (timer_done)
  );

  // ----------------------------------------------------------------------------
  // Flip-flops
  // ----------------------------------------------------------------------------
  // Busy state and its mode survive reset so the byte is not left half written
  always_ff @(posedge I_CLK_SYS)
  begin
    if (!I_RST_N && !busy)
    begin
      state_q  <= EBA_ST_IDLE;
      launch_q <= 1'b0;
      mode_q   <= EBA_MODE_ATOMIC;
    end
    else if (!I_RST_N)
    begin
      state_q  <= state_d;
      launch_q <= launch_d;
    end
    else
    begin
      state_q  <= state_d;
      launch_q <= launch_d;
      mode_q   <= mode_d;
    end
  end

  always_ff @(posedge I_CLK_SYS)
  begin
    if (!I_RST_N)
    begin
      addr_q    <= EBA_ADDR_RST;
      data_q    <= EBA_DATA_RST;
      rie_q     <= 1'b0;
      arm_q     <= 1'b0;
      arm_cnt_q <= 3'h0;
      stall_q   <= 3'h0;
      rdata_q   <= 8'h00;
    end
    else
    begin
      addr_q    <= addr_d;
      data_q    <= data_d;
      rie_q     <= rie_d;
      arm_q     <= arm_d;
      arm_cnt_q <= arm_cnt_d;
      stall_q   <= stall_d;
      rdata_q   <= rdata_d;
    end
  end

  // Operation snapshot; address and data may change after launch without harm
  always_ff @(posedge I_CLK_SYS)
  begin
    if (launch_go && state_q == EBA_ST_IDLE)
    begin
      op_addr_q <= addr_q;
      op_data_q <= data_q;
      op_mode_q <= eba_mode_e'(mode_q);
    end
  end

  // Array cells: erase sets all ones, write alone can only clear bits
  always_ff @(posedge I_CLK_SYS)
  begin
    if (timer_done && state_q == EBA_ST_RUN)
    begin
      unique case (op_mode_q)
        EBA_MODE_ATOMIC: mem_q[op_addr_q] <= op_data_q;
        EBA_MODE_ERASE:  mem_q[op_addr_q] <= EBA_ERASED_BYTE;
        EBA_MODE_WRITE:  mem_q[op_addr_q] <= mem_q[op_addr_q] & op_data_q;
        EBA_MODE_RSVD:   mem_q[op_addr_q] <= mem_q[op_addr_q];
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------------
  assign O_IO_RDATA  = rdata_q;
  assign O_CPU_STALL = (stall_q != 3'h0);
  assign O_READY_IRQ = rie_q && I_GLOBAL_IRQ_EN && !launch_q;
  assign O_PROG_BUSY = launch_q;

endmodule

/* File: core/eba_prog_timer.sv */
// Self-timer counting calibrated oscillator ticks for one programming operation.
// Assumes the tick input is already synchronised and one CPU cycle wide.
`timescale 1ns/100ps
module eba_prog_timer
  import eba_pkg::*;
(
  input  wire logic                 i_clk,
  input  wire logic                 i_rst_n,
  input  wire logic                 i_start,
  input  wire logic [EBA_CNT_W-1:0] i_count,
  input  wire logic                 i_tick,
  output logic                      o_done
);

  logic [EBA_CNT_W-1:0] cnt_q;
  logic [EBA_CNT_W-1:0] cnt_d;
  logic                 run_q;
  logic                 run_d;
  logic                 last_w;

  assign last_w = run_q && i_tick && (cnt_q == {{(EBA_CNT_W-1){1'b0}}, 1'b1});
  assign o_done = last_w;

  always_comb
  begin
    cnt_d = cnt_q;
    run_d = run_q;
    if (i_start)
    begin
      cnt_d = i_count;
      run_d = 1'b1;
    end
    else if (last_w)
    begin
      cnt_d = '0;
      run_d = 1'b0;
    end
    else if (run_q && i_tick)
    begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  // Reset does not stop a running or starting count, so the operation completes
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n && !run_q && !i_start)
    begin
      cnt_q <= '0;
      run_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      run_q <= run_d;
    end
  end

endmodule

/* File: shared/eba_pkg.sv */
// Constants, types and field layout of the EEPROM byte access controller.
// Assumes a single CPU clock of 200 MHz and a calibrated oscillator arriving as a pin.
// ----------------------------------------------------------------------------
// Summary of operation
// ----------------------------------------------------------------------------
// Summary of operation
// - Separate 512-byte data space, each byte read or written on its own.
// - Address holds 9 bits; bits 15..9 read zero; reset value not guaranteed.
// - Data register supplies the byte to program, and receives the byte read.
// - Control bits 7 and 6 always read zero.
// - Mode 00 erase+write, 01 erase only, 10 write only, 11 reserved.
// - Mode writes are ignored while the launch bit is set.
// - Reset returns mode to 00 unless programming is still running.
// - Ready interrupt requested while enabled, global enable set and launch clear.
// - Hardware clears the arm bit four cycles after software sets it.
// - Launch starts programming only while arm is set, otherwise no effect.
// - Programming cannot start while the CPU is writing flash.
// - Hardware clears the launch bit when the programming time has elapsed.
// - Setting launch stalls the CPU for two cycles.
// - Read strobe loads the addressed byte into the data register at once.
// - A read strobe stalls the CPU for four cycles.
// - During a write, reads and address changes are refused.
// - Programming is timed in calibrated oscillator cycles, 26368 per erase+write, 13959 per erase only or write only.
// - A programming operation under way completes across a reset.
package eba_pkg;

  // ----------------------------------------------------------------------------
  // Register indices on the I/O port
  // ----------------------------------------------------------------------------
  localparam logic [1:0] EBA_IDX_ADDR_LO = 2'h0;
  localparam logic [1:0] EBA_IDX_ADDR_HI = 2'h1;
  localparam logic [1:0] EBA_IDX_DATA    = 2'h2;
  localparam logic [1:0] EBA_IDX_CTRL    = 2'h3;

  // ----------------------------------------------------------------------------
  // Field layout and reset values
  // ----------------------------------------------------------------------------
  localparam int         EBA_ADDR_W      = 9;
  localparam int         EBA_MEM_BYTES   = 512;
  localparam int         EBA_BIT_READ    = 0;
  localparam int         EBA_BIT_LAUNCH  = 1;
  localparam int         EBA_BIT_ARM     = 2;
  localparam int         EBA_BIT_RIE     = 3;
  localparam int         EBA_BIT_MODE_LO = 4;
  localparam int         EBA_BIT_MODE_HI = 5;
  localparam logic [8:0] EBA_ADDR_RST    = 9'h000;
  localparam logic [7:0] EBA_DATA_RST    = 8'h00;
  localparam logic [7:0] EBA_ERASED_BYTE = 8'hFF;

  // ----------------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------------
  localparam int         EBA_CLK_MHZ        = 200;
  localparam logic [2:0] EBA_ARM_HOLD_CYC   = 3'h4;
  localparam logic [2:0] EBA_WR_STALL_CYC   = 3'h2;
  localparam logic [2:0] EBA_RD_STALL_CYC   = 3'h4;
  localparam int         EBA_ATOMIC_TIME_US = 3400;
  localparam int         EBA_SPLIT_TIME_US  = 1800;
  localparam int         EBA_WRITE_TIME_US  = 3300;
  localparam int         EBA_WRITE_OSC_CYC  = 26368;
  localparam int         EBA_SPLIT_OSC_CYC  = (EBA_WRITE_OSC_CYC * EBA_SPLIT_TIME_US) / EBA_ATOMIC_TIME_US;
  localparam int         EBA_CNT_W          = 16;

  // ----------------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------------
  typedef enum logic [1:0] {
    EBA_MODE_ATOMIC = 2'b00,
    EBA_MODE_ERASE  = 2'b01,
    EBA_MODE_WRITE  = 2'b10,
    EBA_MODE_RSVD   = 2'b11
  } eba_mode_e;

  typedef enum logic [1:0] {
    EBA_ST_IDLE  = 2'b00,
    EBA_ST_FLASH = 2'b01,
    EBA_ST_RUN   = 2'b10
  } eba_state_e;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [1:0] idx;
    logic [7:0] wdata;
  } eba_io_req_s;

endpackage

/* File: test/eba_ctrl_properties.sv */
// Port checker for the EEPROM byte access controller.
// Assumes one CPU clock and a synchronous active-low reset; bound to eba_ctrl.
`timescale 1ns/100ps
module eba_ctrl_chk
  import eba_pkg::*;
#(
  parameter logic [EBA_CNT_W-1:0] ATOMIC_OSC_CYC = 16'h0004,
  parameter logic [EBA_CNT_W-1:0] SPLIT_OSC_CYC  = 16'h0002
)
(
  input wire logic                I_CLK_SYS,
  input wire logic                I_RST_N,
  input wire eba_pkg::eba_io_req_s I_IO_REQ,
  input wire logic                I_GLOBAL_IRQ_EN,
  input wire logic                I_FLASH_SELFPROG_ENABLE,
  input wire logic                I_CAL_OSC,
  input wire logic [7:0]          O_IO_RDATA,
  input wire logic                O_CPU_STALL,
  input wire logic                O_READY_IRQ,
  input wire logic                O_PROG_BUSY
);
  default clocking @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RST_N);
  // ----------------------------------------------------------------------------
  // Arm window tracker
  // ----------------------------------------------------------------------------
  logic [2:0] arm_cnt_q;
  logic [2:0] arm_cnt_d;
  wire ctl_wr = I_IO_REQ.wr && (I_IO_REQ.idx == EBA_IDX_CTRL);
  wire arm_wr = ctl_wr && I_IO_REQ.wdata[2] && !I_IO_REQ.wdata[1];
  wire go_wr  = ctl_wr && I_IO_REQ.wdata[1] && !O_PROG_BUSY;
  wire rd_go  = ctl_wr && (I_IO_REQ.wdata[1:0] == 2'b01);
  assign arm_cnt_d = arm_wr ? 3'h4 : ((arm_cnt_q != 3'h0) ? arm_cnt_q - 3'h1 : 3'h0);
  always_ff @(posedge I_CLK_SYS)
  begin
    if (!I_RST_N)
      arm_cnt_q <= 3'h0;
    else
      arm_cnt_q <= arm_cnt_d;
  end
  // ----------------------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------------------
  property p_irq_gate;
    O_READY_IRQ |-> I_GLOBAL_IRQ_EN && !O_PROG_BUSY;
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("ready request while launch set or global enable low");
  property p_rd_stall;
    rd_go && !O_PROG_BUSY |=> O_CPU_STALL [*4] ##1 !O_CPU_STALL;
  endproperty
  a_rd_stall: assert property (p_rd_stall)
    else $error("read stall is not four cycles");
  property p_wr_stall;
    $rose(O_PROG_BUSY) |-> O_CPU_STALL [*2] ##1 !O_CPU_STALL;
  endproperty
  a_wr_stall: assert property (p_wr_stall)
    else $error("launch stall is not two cycles");
  property p_arm_ok;
    go_wr && (arm_cnt_q != 3'h0) |=> O_PROG_BUSY;
  endproperty
  a_arm_ok: assert property (p_arm_ok)
    else $error("armed launch did not start programming");
  property p_arm_late;
    go_wr && (arm_cnt_q == 3'h0) |=> !O_PROG_BUSY;
  endproperty
  a_arm_late: assert property (p_arm_late)
    else $error("launch without live arm started programming");
  property p_ctl_zero;
    I_IO_REQ.rd && (I_IO_REQ.idx == EBA_IDX_CTRL) |=> (O_IO_RDATA[7:6] == 2'b00) && !O_IO_RDATA[0];
  endproperty
  a_ctl_zero: assert property (p_ctl_zero)
    else $error("control reserved or read strobe bit reads one");
  property p_hi_zero;
    I_IO_REQ.rd && (I_IO_REQ.idx == EBA_IDX_ADDR_HI) |=> O_IO_RDATA[7:1] == 7'h00;
  endproperty
  a_hi_zero: assert property (p_hi_zero)
    else $error("address high reserved bits read one");
  property p_busy_rd;
    O_PROG_BUSY && !O_CPU_STALL && rd_go |=> !O_CPU_STALL;
  endproperty
  a_busy_rd: assert property (p_busy_rd)
    else $error("read strobe accepted during programming");
  property p_busy_end;
    $rose(O_PROG_BUSY) |-> ##[1:600] !O_PROG_BUSY;
  endproperty
  a_busy_end: assert property (p_busy_end)
    else $error("launch bit never cleared");
  property p_rdata_hold;
    !I_IO_REQ.rd |=> $stable(O_IO_RDATA);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data changed without a read");
endmodule

bind eba_ctrl eba_ctrl_chk #(.ATOMIC_OSC_CYC(ATOMIC_OSC_CYC), .SPLIT_OSC_CYC(SPLIT_OSC_CYC)) u_eba_ctrl_chk (
  .I_CLK_SYS(I_CLK_SYS), .I_RST_N(I_RST_N), .I_IO_REQ(I_IO_REQ), .I_GLOBAL_IRQ_EN(I_GLOBAL_IRQ_EN),
  .I_FLASH_SELFPROG_ENABLE(I_FLASH_SELFPROG_ENABLE), .I_CAL_OSC(I_CAL_OSC), .O_IO_RDATA(O_IO_RDATA),
  .O_CPU_STALL(O_CPU_STALL), .O_READY_IRQ(O_READY_IRQ), .O_PROG_BUSY(O_PROG_BUSY));

/* File: test/eba_ctrl_test.sv */
// Self-checking bench for the EEPROM byte access controller.
// Assumes one-cycle register strobes and read data one cycle after the read edge.
`timescale 1ns/100ps
module eba_ctrl_test;
  import eba_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  eba_io_req_s req = '0;
  logic        gie = 1'b0;
  logic        fse = 1'b0;
  logic        osc = 1'b0;
  logic [7:0]  rdata;
  logic        stall;
  logic        irq;
  logic        busy;
  logic [7:0]  v;
  int          n;
  int          cyc = 0;
  int          error_cnt = 0;
  int          checked = 0;
  logic [7:0]  dat [5] = '{8'hA5, 8'h00, 8'h3C, 8'hF0, 8'h00};
  logic [1:0]  mod [5] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h3};
  logic [7:0]  exp_b [5] = '{8'hA5, 8'hFF, 8'h3C, 8'h30, 8'h30};

  // Short oscillator counts keep each programming run to tens of cycles
  eba_ctrl #(.ATOMIC_OSC_CYC(16'h0004), .SPLIT_OSC_CYC(16'h0002)) u_eba_ctrl (
    .I_CLK_SYS(clk), .I_RST_N(rst_n), .I_IO_REQ(req), .I_GLOBAL_IRQ_EN(gie),
    .I_FLASH_SELFPROG_ENABLE(fse), .I_CAL_OSC(osc), .O_IO_RDATA(rdata),
    .O_CPU_STALL(stall), .O_READY_IRQ(irq), .O_PROG_BUSY(busy));

  initial forever #2.5 clk = ~clk;
  initial forever #20 osc = ~osc;

  // ----------------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] ex, input string m);
    checked++;
    if (got !== ex)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, m, got, ex);
    end
  endtask
  task automatic io(input logic r, input logic [1:0] i, input logic [7:0] d);
    @(posedge clk);
    #1 req = {!r, r, i, d};
    @(posedge clk);
    #1 req = '0;
    v = rdata;
  endtask
  task automatic cnt_stall();
    n = 0;
    while (stall !== 1'b0 && n < 10)
    begin
      @(posedge clk);
      #1 n++;
    end
  endtask
  task automatic set_addr(input logic [8:0] a);
    io(1'b0, EBA_IDX_ADDR_LO, a[7:0]);
    io(1'b0, EBA_IDX_ADDR_HI, {7'h00, a[8]});
  endtask
  task automatic eerd(input logic [8:0] a);
    set_addr(a);
    io(1'b0, EBA_IDX_CTRL, 8'h01);
    cnt_stall();
    chk(n[7:0], 8'h04, "read stall");
    io(1'b1, EBA_IDX_DATA, 8'h00);
  endtask
  task automatic prog(input logic [8:0] a, input logic [7:0] d, input logic [1:0] m);
    set_addr(a);
    io(1'b0, EBA_IDX_DATA, d);
    io(1'b0, EBA_IDX_CTRL, {2'b00, m, 4'h4});
    io(1'b0, EBA_IDX_CTRL, {2'b00, m, 4'h2});
    chk({7'h00, busy}, 8'h01, "launch");
    cnt_stall();
    chk(n[7:0], 8'h02, "launch stall");
  endtask
  task automatic idle();
    n = 0;
    while (busy !== 1'b0 && n < 3000)
    begin
      @(posedge clk);
      #1 n++;
    end
    chk({7'h00, busy}, 8'h00, "completion");
  endtask
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Ceiling is far above the several hundred cycles the sequence needs
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      error_cnt++;
      tally_and_finish();
    end
  end

  // ----------------------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------------------
  initial
  begin
    repeat (20) @(posedge clk);
    #1 rst_n = 1'b1;
    io(1'b1, EBA_IDX_CTRL, 8'h00);
    chk(v, 8'h00, "control after reset");
    io(1'b0, EBA_IDX_ADDR_HI, 8'hFF);
    io(1'b1, EBA_IDX_ADDR_HI, 8'h00);
    chk(v, 8'h01, "address high");
    for (int k = 0; k < 5; k++)
    begin
      prog(9'h105, dat[k], mod[k]);
      idle();
      // Two ticks for a split mode, four otherwise, eight clocks per tick
      chk({7'h00, ((mod[k] == 2'h1 || mod[k] == 2'h2) ? (n <= 16) : (n >= 20))}, 8'h01, "programming time");
      eerd(9'h105);
      chk(v, exp_b[k], "mode result");
    end
    prog(9'h005, 8'h11, 2'h0);
    idle();
    eerd(9'h105);
    chk(v, 8'h30, "upper byte kept");
    eerd(9'h005);
    chk(v, 8'h11, "lower byte");
    io(1'b0, EBA_IDX_CTRL, 8'h02);
    chk({7'h00, busy}, 8'h00, "launch without arm");
    for (int k = 2; k < 4; k++)
    begin
      io(1'b0, EBA_IDX_CTRL, 8'h04);
      repeat (k) @(posedge clk);
      io(1'b0, EBA_IDX_CTRL, 8'h02);
      chk({7'h00, busy}, {7'h00, k == 2}, "arm window edge");
      idle();
    end
    fse = 1'b1;
    prog(9'h005, 8'h77, 2'h1);
    io(1'b0, EBA_IDX_ADDR_LO, 8'h99);
    io(1'b0, EBA_IDX_CTRL, 8'h21);
    cnt_stall();
    chk(n[7:0], 8'h00, "read during write");
    io(1'b1, EBA_IDX_CTRL, 8'h00);
    chk(v, 8'h12, "mode kept while busy");
    repeat (60) @(posedge clk);
    #1 chk({7'h00, busy}, 8'h01, "held by flash");
    fse = 1'b0;
    idle();
    io(1'b1, EBA_IDX_ADDR_LO, 8'h00);
    chk(v, 8'h05, "address kept");
    eerd(9'h005);
    chk(v, 8'hFF, "erase only");
    gie = 1'b1;
    io(1'b0, EBA_IDX_CTRL, 8'h08);
    chk({7'h00, irq}, 8'h01, "ready request");
    gie = 1'b0;
    #1 chk({7'h00, irq}, 8'h00, "global gate");
    gie = 1'b1;
    set_addr(9'h105);
    io(1'b0, EBA_IDX_CTRL, 8'h1C);
    io(1'b0, EBA_IDX_CTRL, 8'h1A);
    chk({7'h00, irq}, 8'h00, "busy gate");
    @(posedge clk);
    #1 rst_n = 1'b0;
    repeat (3) @(posedge clk);
    #1 rst_n = 1'b1;
    chk({7'h00, busy}, 8'h01, "busy across reset");
    io(1'b1, EBA_IDX_CTRL, 8'h00);
    chk(v, 8'h12, "mode across reset");
    idle();
    eerd(9'h105);
    chk(v, 8'hFF, "finished across reset");
    tally_and_finish();
  end
endmodule
